// ### logic/ppc_pkg.sv
// port phy control package: register indices, field layout, reset values, alias mapping
// assumes a 32-bit AHB-Lite register bus where byte address = 4 * register index
//
// Functional notes
// - led-off bit 15 set drives all four port led outputs high
// - bit 14 set disables the port transmitter
// - writing one to bit 13 restarts auto-negotiation
// - bit 12 set disables far-end fault detection and fault pattern sending
// - bit 10 set disables automatic mdi/mdix crossover
// - bit 9 forces mdix only while automatic crossover is disabled
// - bit 7 enables auto-negotiation, reset 1; clear means speed/duplex from bits 6/5
// - auto-negotiation off: bit 6 one gives 100 mbps, zero gives 10 mbps
// - auto-negotiation off or failed: bit 5 selects full or half duplex
// - bit 4, reset 1, advertises pause capability
// - bit 3, reset 1, advertises 100 mbps full duplex
// - bit 2, reset 1, advertises 100 mbps half duplex
// - bit 1, reset 1, advertises 10 mbps full duplex
// - bit 0, reset 1, advertises 10 mbps half duplex
package ppc_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [11:0] PPC_IDX_CTRL = 12'h512;
    localparam logic [11:0] PPC_IDX_BASIC = 12'h500;
    localparam logic [11:0] PPC_IDX_ADV = 12'h501;
    localparam logic [11:0] PPC_IDX_STAT = 12'h520;

    // ----------------------------------------------------------------
    // reset values and write mask
    // ----------------------------------------------------------------
    localparam logic [15:0] PPC_CTRL_RST = 16'h009F;
    localparam logic [15:0] PPC_CTRL_WMASK = 16'hFEFF;
    localparam logic [3:0] PPC_LED_OFF = 4'hF;

    // ----------------------------------------------------------------
    // basic control view bit positions
    // ----------------------------------------------------------------
    localparam int PPC_B_LED = 0;
    localparam int PPC_B_TXDIS = 1;
    localparam int PPC_B_FEF = 2;
    localparam int PPC_B_MDIXDIS = 3;
    localparam int PPC_B_MDIXF = 4;
    localparam int PPC_B_DUPLEX = 8;
    localparam int PPC_B_RESTART = 9;
    localparam int PPC_B_PWRDN = 11;
    localparam int PPC_B_ANEN = 12;
    localparam int PPC_B_SPEED = 13;
    localparam int PPC_B_RSVD = 14;

    // status register bit positions
    localparam int PPC_S_SPEED = 0;
    localparam int PPC_S_DUPLEX = 1;
    localparam int PPC_S_MDIX = 2;
    localparam int PPC_S_ANDONE = 3;
    localparam int PPC_S_ANFAIL = 4;

    // control register layout, msb first
    typedef struct packed {
        logic led_off;
        logic tx_dis;
        logic an_restart;
        logic fef_dis;
        logic pwr_down;
        logic mdix_auto_dis;
        logic mdix_force;
        logic rsvd;
        logic an_en;
        logic force_100;
        logic force_full;
        logic [4:0] adv;
    } ppc_ctl_s;

    typedef enum logic [1:0] {
        PPC_ST_IDLE = 2'b00,
        PPC_ST_WR = 2'b01,
        PPC_ST_RD_WAIT = 2'b11,
        PPC_ST_RD_DONE = 2'b10
    } ppc_bus_e;

    // ----------------------------------------------------------------
    // decode and alias functions
    // ----------------------------------------------------------------
    function automatic logic ppc_idx_ok(input logic [31:0] addr);
        logic [11:0] idx;
        idx = addr[13:2];
        return (addr[31:14] == 18'h00000) &&
            (idx == PPC_IDX_CTRL || idx == PPC_IDX_BASIC ||
             idx == PPC_IDX_ADV || idx == PPC_IDX_STAT);
    endfunction : ppc_idx_ok

    function automatic logic [15:0] ppc_to_basic(input ppc_ctl_s c);
        logic [15:0] v;
        v = 16'h0000;
        v[PPC_B_LED] = c.led_off;
        v[PPC_B_TXDIS] = c.tx_dis;
        v[PPC_B_FEF] = c.fef_dis;
        v[PPC_B_MDIXDIS] = c.mdix_auto_dis;
        v[PPC_B_MDIXF] = c.mdix_force;
        v[PPC_B_DUPLEX] = c.force_full;
        v[PPC_B_RESTART] = c.an_restart;
        v[PPC_B_PWRDN] = c.pwr_down;
        v[PPC_B_ANEN] = c.an_en;
        v[PPC_B_SPEED] = c.force_100;
        v[PPC_B_RSVD] = c.rsvd;
        return v;
    endfunction : ppc_to_basic

    function automatic ppc_ctl_s ppc_from_basic(input ppc_ctl_s c, input logic [15:0] w);
        ppc_ctl_s n;
        n = c;
        n.led_off = w[PPC_B_LED];
        n.tx_dis = w[PPC_B_TXDIS];
        n.fef_dis = w[PPC_B_FEF];
        n.mdix_auto_dis = w[PPC_B_MDIXDIS];
        n.mdix_force = w[PPC_B_MDIXF];
        n.force_full = w[PPC_B_DUPLEX];
        n.an_restart = w[PPC_B_RESTART];
        n.pwr_down = w[PPC_B_PWRDN];
        n.an_en = w[PPC_B_ANEN];
        n.force_100 = w[PPC_B_SPEED];
        return n;
    endfunction : ppc_from_basic

endpackage : ppc_pkg

// ### logic/ppc_ahb_slave.sv
// ahb-lite slave front end for the port phy control registers
// assumes hready_i is this slave's own hreadyout looped back by the fabric
`timescale 1ns/1ps
module ppc_ahb_slave
    import ppc_pkg::*;
(
    input wire logic ref_clk_i, // 25 mhz clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic hsel_i, // slave select
    input wire logic [31:0] haddr_i, // byte address
    input wire logic [1:0] htrans_i, // transfer type
    input wire logic hwrite_i, // write when high
    input wire logic [2:0] hsize_i, // transfer size, word only
    input wire logic [31:0] hwdata_i, // write data
    input wire logic hready_i, // bus ready
    output logic [31:0] hrdata_o, // read data
    output logic hreadyout_o, // slave ready
    output logic hresp_o, // always okay
    output logic wr_en_o, // register write strobe
    output logic [11:0] wr_idx_o, // register index to write
    output logic [15:0] wr_data_o, // write data
    output logic [11:0] rd_idx_o, // register index to read
    input wire logic [15:0] rd_data_i // read value for rd_idx_o
);
    import ppc_pkg::*;

    ppc_bus_e state_q;
    logic hready_q;
    logic [31:0] hrdata_q;
    logic [11:0] idx_q;
    logic ok_q;
    logic take;

    assign take = hsel_i && htrans_i[1] && hready_i;
    assign hrdata_o = hrdata_q;
    assign hreadyout_o = hready_q;
    assign hresp_o = 1'b0;
    assign wr_en_o = (state_q == PPC_ST_WR) && ok_q;
    assign wr_idx_o = idx_q;
    assign wr_data_o = hwdata_i[15:0];
    assign rd_idx_o = idx_q;

    // ----------------------------------------------------------------
    // transfer sequencing: writes zero wait, reads one wait state
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_q <= PPC_ST_IDLE;
            hready_q <= 1'b1;
            hrdata_q <= 32'h00000000;
            idx_q <= 12'h000;
            ok_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                PPC_ST_RD_WAIT:
                begin
                    hrdata_q <= ok_q ? {16'h0000, rd_data_i} : 32'h00000000;
                    hready_q <= 1'b1;
                    state_q <= PPC_ST_RD_DONE;
                end
                PPC_ST_IDLE, PPC_ST_WR, PPC_ST_RD_DONE:
                begin
                    if (take)
                    begin
                        idx_q <= haddr_i[13:2];
                        ok_q <= ppc_idx_ok(haddr_i);
                        state_q <= hwrite_i ? PPC_ST_WR : PPC_ST_RD_WAIT;
                        hready_q <= hwrite_i;
                    end
                    else
                    begin
                        state_q <= PPC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence rd_taken;
        take && !hwrite_i;
    endsequence

    AST_RD_ONE_WAIT: assert property (rd_taken |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read did not answer after exactly one wait state");
    AST_WR_STROBE: assert property (take && hwrite_i |=> hreadyout_o && wr_en_o == ok_q)
        else $error("write data phase strobe or ready wrong");
endmodule : ppc_ahb_slave

// ### logic/ppc_top.sv
// port phy control register bank with basic-control and advertisement alias views
// assumes phy status inputs arrive asynchronously and led activity comes from this clock
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
module ppc_top
    import ppc_pkg::*;
(
    input wire logic ref_clk_i, // 25 mhz clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic hsel_i, // ahb slave select
    input wire logic [31:0] haddr_i, // ahb byte address
    input wire logic [1:0] htrans_i, // ahb transfer type
    input wire logic hwrite_i, // ahb write
    input wire logic [2:0] hsize_i, // ahb size
    input wire logic [31:0] hwdata_i, // ahb write data
    input wire logic hready_i, // ahb bus ready
    output logic [31:0] hrdata_o, // ahb read data
    output logic hreadyout_o, // ahb slave ready
    output logic hresp_o, // ahb response, okay
    input wire logic [3:0] led_act_i, // normal led drive, 0 lights
    input wire logic an_done_i, // phy: negotiation complete
    input wire logic an_fail_i, // phy: negotiation failed
    input wire logic an_speed_100_i, // phy: negotiated 100 mbps
    input wire logic an_full_i, // phy: negotiated full duplex
    output logic port_led_out_zero_o, // led pin 0, high is off
    output logic port_led_out_one_o, // led pin 1, high is off
    output logic port_led_out_two_o, // led pin 2, high is off
    output logic port_led_out_three_o, // led pin 3, high is off
    output logic tx_disable_o, // transmitter disabled
    output logic an_restart_o, // one-cycle restart pulse
    output logic fef_disable_o, // far-end fault logic disabled
    output logic power_down_o, // phy powered down
    output logic mdix_auto_en_o, // automatic crossover enabled
    output logic mdix_force_o, // forced mdix mode
    output logic an_enable_o, // negotiation enabled
    output logic speed_100_o, // resolved speed is 100 mbps
    output logic full_duplex_o, // resolved duplex is full
    output logic [4:0] advert_o // advertised abilities
);
    import ppc_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ppc_ctl_s ctl_q;
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic an_done_s;
    logic an_fail_s;
    logic an_speed_s;
    logic an_full_s;
    logic wr_en;
    logic [11:0] wr_idx;
    logic [15:0] wr_data;
    logic [11:0] rd_idx;
    logic [15:0] rd_data;
    logic [15:0] stat;
    logic [3:0] led_q;
    logic tx_dis_q;
    logic restart_q;
    logic fef_q;
    logic pwr_q;
    logic mdix_auto_q;
    logic mdix_force_q;
    logic an_en_q;
    logic speed_q;
    logic full_q;
    logic [4:0] adv_q;

    // ----------------------------------------------------------------
    // bus front end
    // ----------------------------------------------------------------
    ppc_ahb_slave u_bus (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hready_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .wr_en_o(wr_en),
        .wr_idx_o(wr_idx),
        .wr_data_o(wr_data),
        .rd_idx_o(rd_idx),
        .rd_data_i(rd_data)
    );

    // ----------------------------------------------------------------
    // phy status synchronisers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_sync
            always_ff @(posedge ref_clk_i)
            begin
                if (rst_i)
                begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end
                else
                begin
                    meta_q[g] <= (g == 0) ? an_done_i : (g == 1) ? an_fail_i :
                        (g == 2) ? an_speed_100_i : an_full_i;
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign an_done_s = sync_q[0];
    assign an_fail_s = sync_q[1];
    assign an_speed_s = sync_q[2];
    assign an_full_s = sync_q[3];

    // ----------------------------------------------------------------
    // control register, written through any of three views
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            ctl_q <= PPC_CTRL_RST;
        end
        else if (wr_en && wr_idx == PPC_IDX_CTRL)
        begin
            ctl_q <= wr_data & PPC_CTRL_WMASK;
        end
        else if (wr_en && wr_idx == PPC_IDX_BASIC)
        begin
            ctl_q <= ppc_from_basic(ctl_q, wr_data);
        end
        else if (wr_en && wr_idx == PPC_IDX_ADV)
        begin
            ctl_q.adv <= wr_data[4:0];
            ctl_q.an_restart <= 1'b0;
        end
        else
        begin
            ctl_q.an_restart <= 1'b0; // restart bit self-clears the cycle after it is set, on the edge that starts its output pulse
        end
    end

    // ----------------------------------------------------------------
    // read mux and status
    // ----------------------------------------------------------------
    always_comb
    begin
        stat = 16'h0000;
        stat[PPC_S_SPEED] = speed_q;
        stat[PPC_S_DUPLEX] = full_q;
        stat[PPC_S_MDIX] = mdix_force_q;
        stat[PPC_S_ANDONE] = an_done_s;
        stat[PPC_S_ANFAIL] = an_fail_s;
    end

    always_comb
    begin
        unique case (rd_idx)
            PPC_IDX_CTRL: rd_data = ctl_q;
            PPC_IDX_BASIC: rd_data = ppc_to_basic(ctl_q);
            PPC_IDX_ADV: rd_data = {11'h000, ctl_q.adv};
            PPC_IDX_STAT: rd_data = stat;
            default: rd_data = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // led drive
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            led_q <= PPC_LED_OFF;
        end
        else
        begin
            led_q <= ctl_q.led_off ? PPC_LED_OFF : led_act_i;
        end
    end

    assign port_led_out_zero_o = led_q[0];
    assign port_led_out_one_o = led_q[1];
    assign port_led_out_two_o = led_q[2];
    assign port_led_out_three_o = led_q[3];

    // ----------------------------------------------------------------
    // phy control outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            tx_dis_q <= 1'b0;
            restart_q <= 1'b0;
            fef_q <= 1'b0;
            pwr_q <= 1'b0;
            mdix_auto_q <= 1'b1;
            mdix_force_q <= 1'b0;
        end
        else
        begin
            tx_dis_q <= ctl_q.tx_dis;
            restart_q <= ctl_q.an_restart;
            fef_q <= ctl_q.fef_dis;
            pwr_q <= ctl_q.pwr_down;
            mdix_auto_q <= !ctl_q.mdix_auto_dis;
            mdix_force_q <= ctl_q.mdix_auto_dis && ctl_q.mdix_force;
        end
    end

    // ----------------------------------------------------------------
    // speed, duplex and advertisement resolution
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            an_en_q <= 1'b1;
            speed_q <= 1'b0;
            full_q <= 1'b0;
            adv_q <= PPC_CTRL_RST[4:0];
        end
        else
        begin
            an_en_q <= ctl_q.an_en;
            speed_q <= ctl_q.an_en ? an_speed_s : ctl_q.force_100;
            full_q <= (ctl_q.an_en && !an_fail_s) ? an_full_s : ctl_q.force_full;
            adv_q <= ctl_q.adv;
        end
    end

    assign tx_disable_o = tx_dis_q;
    assign an_restart_o = restart_q;
    assign fef_disable_o = fef_q;
    assign power_down_o = pwr_q;
    assign mdix_auto_en_o = mdix_auto_q;
    assign mdix_force_o = mdix_force_q;
    assign an_enable_o = an_en_q;
    assign speed_100_o = speed_q;
    assign full_duplex_o = full_q;
    assign advert_o = adv_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence restart_written;
        wr_en && ((wr_idx == PPC_IDX_CTRL && wr_data[13]) ||
            (wr_idx == PPC_IDX_BASIC && wr_data[PPC_B_RESTART]));
    endsequence

    sequence restart_pulse;
        ctl_q.an_restart ##1 an_restart_o;
    endsequence

    AST_LED_OFF: assert property (ctl_q.led_off |=> led_q == 4'hF)
        else $error("leds not forced high while led-off set");
    AST_LED_FOLLOW: assert property (!rst_i && !ctl_q.led_off |=> led_q == $past(led_act_i))
        else $error("leds do not follow activity in normal mode");
    AST_TXDIS: assert property (##1 tx_disable_o == $past(ctl_q.tx_dis))
        else $error("transmit disable does not track its bit");
    AST_RESTART: assert property (restart_written |=> restart_pulse)
        else $error("restart write did not give restart pulse");
    AST_FEF: assert property ($rose(ctl_q.fef_dis) |=> fef_disable_o)
        else $error("far-end fault not disabled");
    AST_MDIX: assert property (##1 mdix_auto_en_o == !$past(ctl_q.mdix_auto_dis)
        && mdix_force_o == ($past(ctl_q.mdix_auto_dis) && $past(ctl_q.mdix_force)))
        else $error("crossover control wrong");
    AST_SPEED: assert property (!ctl_q.an_en |=> speed_100_o == $past(ctl_q.force_100))
        else $error("forced speed not applied");
    AST_DUPLEX: assert property ((!ctl_q.an_en || an_fail_s)
        |=> full_duplex_o == $past(ctl_q.force_full))
        else $error("forced duplex not applied");
    AST_ANEN: assert property ($fell(ctl_q.an_en) |=> !an_enable_o)
        else $error("negotiation enable output stale");
    AST_ADV: assert property (##1 advert_o == $past(ctl_q.adv))
        else $error("advertised abilities do not track register");
    AST_PWR: assert property (ctl_q.pwr_down [*2] |-> power_down_o)
        else $error("power down not applied");
    AST_ALIAS: assert property (wr_en && wr_idx == PPC_IDX_BASIC
        |=> ctl_q.led_off == $past(wr_data[PPC_B_LED])
        && ppc_to_basic(ctl_q) == ppc_to_basic(ppc_from_basic($past(ctl_q), $past(wr_data))))
        else $error("basic view write not seen in control register");
endmodule : ppc_top

// ### testbench/port_phy_control_register_tb.sv
// self-checking bench for the port phy control register bank
// assumes ppc_top is the only ahb-lite slave, its hreadyout looped back as hready
`timescale 1ns/1ps
module port_phy_control_register_tb;
    import ppc_pkg::*;

    localparam logic [31:0] A_CTRL = {18'h00000, PPC_IDX_CTRL, 2'b00};
    localparam logic [31:0] A_BASIC = {18'h00000, PPC_IDX_BASIC, 2'b00};
    localparam logic [31:0] A_ADV = {18'h00000, PPC_IDX_ADV, 2'b00};
    localparam logic [31:0] A_STAT = {18'h00000, PPC_IDX_STAT, 2'b00};
    localparam logic [31:0] A_BAD = 32'h00011448;

    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h00000000;
    logic [1:0] htrans_i = 2'b00;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h00000000;
    logic [3:0] led_act_i = 4'h0;
    logic an_done_i = 1'b0;
    logic an_fail_i = 1'b0;
    logic an_speed_100_i = 1'b0;
    logic an_full_i = 1'b0;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic led0, led1, led2, led3;
    logic tx_dis, an_rst, fef_dis, pwr_dn, mdix_auto, mdix_frc, an_en, spd, dup;
    logic [4:0] advert_o;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [31:0] view_addr [4] = '{A_CTRL, A_BASIC, A_ADV, A_BAD};

    always #20 ref_clk_i = ~ref_clk_i;

    ppc_top DUT (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .led_act_i(led_act_i), .an_done_i(an_done_i),
        .an_fail_i(an_fail_i), .an_speed_100_i(an_speed_100_i), .an_full_i(an_full_i),
        .port_led_out_zero_o(led0), .port_led_out_one_o(led1),
        .port_led_out_two_o(led2), .port_led_out_three_o(led3),
        .tx_disable_o(tx_dis), .an_restart_o(an_rst), .fef_disable_o(fef_dis),
        .power_down_o(pwr_dn), .mdix_auto_en_o(mdix_auto), .mdix_force_o(mdix_frc),
        .an_enable_o(an_en), .speed_100_o(spd), .full_duplex_o(dup), .advert_o(advert_o)
    );

    // ----------------------------------------------------------------
    // checking and expectation helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    function automatic logic [31:0] outs();
        return {15'h0000, led3, led2, led1, led0, tx_dis, fef_dis, pwr_dn, mdix_auto,
            mdix_frc, an_en, spd, dup, advert_o};
    endfunction : outs

    // expected port outputs for a control value under the present phy inputs
    function automatic logic [31:0] exp_out(input logic [15:0] m);
        logic [3:0] led;
        led = m[15] ? 4'hF : led_act_i;
        return {15'h0000, led, m[14], m[12], m[11], !m[10], m[10] & m[9], m[7],
            m[7] ? an_speed_100_i : m[6], (m[7] && !an_fail_i) ? an_full_i : m[5], m[4:0]};
    endfunction : exp_out

    // basic control view layout of a control value
    function automatic logic [31:0] exp_basic(input logic [15:0] m);
        return {18'h00000, m[6], m[7], m[11], 1'b0, m[13], m[5], 3'b000, m[9], m[10], m[12],
            m[14], m[15]};
    endfunction : exp_basic

    // status view: resolved speed, duplex, forced mdix, synced phy flags
    function automatic logic [31:0] exp_stat(input logic [15:0] m);
        logic [31:0] e;
        e = exp_out(m);
        return {27'h0000000, an_fail_i, an_done_i, e[8], e[5], e[6]};
    endfunction : exp_stat

    // ----------------------------------------------------------------
    // ahb-lite single word master
    // ----------------------------------------------------------------
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge ref_clk_i);
        while (hreadyout_o !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge ref_clk_i);
        end
        if (n == 16)
            chk("bus wait", 32'h00000000, 32'h00000001);
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [31:0] addr, input logic [15:0] d,
        output logic [31:0] rd);
        hsel_i <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i <= addr;
        hwrite_i <= wr;
        wait_ready();
        hsel_i <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= {16'($urandom), d};
        wait_ready();
        rd = hrdata_o;
        chk("response", {31'h00000000, hresp_o}, 32'h00000000);
    endtask : bus

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [15:0] m;
        logic [15:0] d;
        logic [31:0] rd;
        logic [31:0] addr;
        void'($urandom(32'hA68523EC));
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        m = 16'h009F;
        chk("reset outputs", outs(), exp_out(m));
        bus(1'b0, A_CTRL, 16'h0000, rd);
        chk("reset ctrl", rd, 32'h0000009F);
        // views in turn: control, basic, advert, unmapped; all ones and zeros first
        for (int i = 0; i < 40; i++)
        begin
            d = (i < 4) ? 16'hFFFF : (i < 8) ? 16'h0000 : 16'($urandom);
            led_act_i <= 4'($urandom);
            {an_done_i, an_fail_i, an_speed_100_i, an_full_i} <= 4'($urandom);
            addr = view_addr[i % 4];
            if (i % 4 == 0)
                m = d & 16'hFEFF;
            else if (i % 4 == 1)
                m = {d[0], d[1], d[9], d[2], d[11], d[3], d[4], 1'b0, d[12], d[13], d[8], m[4:0]};
            else if (i % 4 == 2)
                m[4:0] = d[4:0];
            bus(1'b1, addr, d, rd);
            @(posedge ref_clk_i);
            #1;
            chk("restart pulse", {31'h00000000, an_rst}, {31'h00000000, m[13]});
            chk("outputs", outs(), exp_out(m));
            @(posedge ref_clk_i);
            #1;
            chk("restart end", {31'h00000000, an_rst}, 32'h00000000);
            m[13] = 1'b0;
            bus(1'b0, A_CTRL, 16'h0000, rd);
            chk("ctrl read", rd, {16'h0000, m});
            bus(1'b0, A_ADV, 16'h0000, rd);
            chk("advert read", rd, {27'h0000000, m[4:0]});
            bus(1'b0, A_BASIC, 16'h0000, rd);
            chk("basic read", rd, exp_basic(m));
            bus(1'b0, A_STAT, 16'h0000, rd);
            chk("status read", rd, exp_stat(m));
            bus(1'b0, A_BAD, 16'h0000, rd);
            chk("unmapped read", rd, 32'h00000000);
        end
        print_verdict();
    end

    // cuts a hung bus short
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        print_verdict();
    end
endmodule : port_phy_control_register_tb
